// ---- inc/supply_monitor_pkg.sv ----
// shared constants and types for the supply monitor register block
package supply_monitor_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CODE_W = 5;
    localparam int EVT_W  = 2;

    localparam logic [ADDR_W-1:0] OFS_ENABLE    = 16'h5100;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD = 16'h5101;
    localparam logic [ADDR_W-1:0] OFS_RESULT    = 16'h5102;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 16'h5103;
    localparam logic [ADDR_W-1:0] OFS_MASK      = 16'h5104;

    localparam int BIT_DETECT_EN = 0;
    localparam int BIT_FLAG      = 0;
    localparam int EVT_BELOW     = 0;
    localparam int EVT_RECOVER   = 1;

    localparam logic              RESET_EN     = 1'h0;
    localparam logic              RESET_FLAG   = 1'h0;
    localparam logic [CODE_W-1:0] RESET_CODE   = 5'h00;
    localparam logic [EVT_W-1:0]  RESET_EVT    = 2'h0;
    localparam logic [DATA_W-1:0] RESET_RDATA  = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_DETECT = 2'b10
    } mon_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        mon_state_t        state;
        logic              detect_enable;
        logic [CODE_W-1:0] threshold_code;
        logic              sync_1;
        logic              sync_2;
        logic              primed;
        logic              undervoltage_flag;
        logic [EVT_W-1:0]  status;
        logic [EVT_W-1:0]  mask;
        logic              irq;
        logic [DATA_W-1:0] rdata;
    } mon_regs_t;

    localparam mon_regs_t MON_RESET = '{
        state: ST_IDLE, detect_enable: RESET_EN, threshold_code: RESET_CODE,
        sync_1: 1'h0, sync_2: 1'h0, primed: 1'h0, undervoltage_flag: RESET_FLAG,
        status: RESET_EVT, mask: RESET_EVT, irq: 1'h0, rdata: RESET_RDATA
    };

endpackage

// ---- rtl/supply_monitor_ctrl.sv ----
// register-side control of the supply undervoltage comparator
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns


module supply_monitor_ctrl
    import supply_monitor_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire reg_req_t          req,
    output logic [DATA_W-1:0]      rdata,
    input  wire logic              cmp_below,
    output logic                   cmp_enable,
    output logic [CODE_W-1:0]      cmp_threshold,
    output logic                   irq
);

    mon_regs_t        st;
    mon_regs_t        next_st;
    logic [EVT_W-1:0] evt;

    logic wr_enable;
    logic wr_threshold;
    logic wr_mask;
    logic rd_status;

    assign wr_enable    = req.wr && (req.addr == OFS_ENABLE);
    assign wr_threshold = req.wr && (req.addr == OFS_THRESHOLD);
    assign wr_mask      = req.wr && (req.addr == OFS_MASK);
    assign rd_status    = req.rd && (req.addr == OFS_STATUS);

    always_comb begin
        next_st = st;
        evt     = '0;

        // first stage feeds only the second one
        next_st.sync_1 = cmp_below;
        next_st.sync_2 = st.sync_1;
        next_st.primed = (st.state == ST_DETECT);

        case (st.state)
            ST_IDLE: begin
                if (wr_enable && req.wdata[BIT_DETECT_EN]) begin
                    next_st.state         = ST_DETECT;
                    next_st.detect_enable = 1'b1;
                end
            end
            ST_DETECT: begin
                // one-means-low polarity carried straight from the comparator
                next_st.undervoltage_flag = st.sync_2;
                // the write cycle itself samples the outcome, so the
                // frozen value is what stood at the moment of the write
                if (wr_enable && !req.wdata[BIT_DETECT_EN]) begin
                    next_st.state         = ST_IDLE;
                    next_st.detect_enable = 1'b0;
                end
                // no events on the first live cycle: the flag still
                // holds the old frozen value and a bogus edge would show
                if (st.primed && st.sync_2 && !st.undervoltage_flag) begin
                    evt[EVT_BELOW] = 1'b1;
                end
                if (st.primed && !st.sync_2 && st.undervoltage_flag) begin
                    evt[EVT_RECOVER] = 1'b1;
                end
            end
            default: begin
                next_st.state         = ST_IDLE;
                next_st.detect_enable = 1'b0;
            end
        endcase

        // reserved codes are stored as written; software keeps clear of them
        if (wr_threshold) begin
            next_st.threshold_code = req.wdata[CODE_W-1:0];
        end
        if (wr_mask) begin
            next_st.mask = req.wdata[EVT_W-1:0];
        end

        // a new event wins over the clear-on-read of the same cycle
        next_st.status = (rd_status ? RESET_EVT : st.status) | evt;
        next_st.irq    = |(next_st.status & next_st.mask);

        next_st.rdata = RESET_RDATA;
        if (req.rd) begin
            case (req.addr)
                OFS_ENABLE: begin
                    next_st.rdata[BIT_DETECT_EN] = st.detect_enable;
                end
                OFS_THRESHOLD: begin
                    next_st.rdata[CODE_W-1:0] = st.threshold_code;
                end
                OFS_RESULT: begin
                    next_st.rdata[BIT_FLAG] = st.undervoltage_flag;
                end
                OFS_STATUS: begin
                    next_st.rdata[EVT_W-1:0] = st.status;
                end
                OFS_MASK: begin
                    next_st.rdata[EVT_W-1:0] = st.mask;
                end
                default: begin
                    next_st.rdata = RESET_RDATA;
                end
            endcase
        end
    end

    // flag reset value is a defined zero, though software must not rely on it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= MON_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rdata         = st.rdata;
    assign cmp_enable    = st.detect_enable;
    assign cmp_threshold = st.threshold_code;
    assign irq           = st.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence seq_enable_write;
        req.wr && req.addr == OFS_ENABLE && req.wdata[BIT_DETECT_EN];
    endsequence

    sequence seq_disable_write;
        req.wr && req.addr == OFS_ENABLE && !req.wdata[BIT_DETECT_EN];
    endsequence

    sequence seq_live_run;
        cmp_enable [*4];
    endsequence

    sequence seq_threshold_write;
        req.wr && req.addr == OFS_THRESHOLD;
    endsequence

    sequence seq_result_write;
        req.wr && req.addr == OFS_RESULT;
    endsequence

    sequence seq_status_read;
        req.rd && req.addr == OFS_STATUS;
    endsequence

    // first live cycle: the flag still holds the old frozen value
    sequence seq_first_live;
        st.state == ST_DETECT && !st.primed;
    endsequence

    property p_enable_starts;
        seq_enable_write |=> cmp_enable && st.state == ST_DETECT;
    endproperty

    property p_disable_freezes;
        seq_disable_write ##0 (st.state == ST_DETECT)
            |=> !cmp_enable && st.undervoltage_flag == $past(st.sync_2);
    endproperty

    property p_frozen_holds;
        !cmp_enable && $past(!cmp_enable) |-> $stable(st.undervoltage_flag);
    endproperty

    property p_live_follow;
        seq_live_run |-> st.undervoltage_flag == $past(cmp_below, 3);
    endproperty

    chk_enable_starts: assert property (p_enable_starts)
        else $error("enable write did not start detection");

    chk_disable_freeze: assert property (p_disable_freezes)
        else $error("disable write did not capture the outcome");

    chk_frozen_hold: assert property (p_frozen_holds)
        else $error("flag changed while detection was off");

    chk_live_flag: assert property (p_live_follow)
        else $error("flag does not follow the comparator");

    chk_result_read: assert property (
        req.rd && req.addr == OFS_RESULT
            |=> rdata == {7'h00, $past(st.undervoltage_flag)})
        else $error("result read returned wrong value");

    chk_threshold_write: assert property (
        req.wr && req.addr == OFS_THRESHOLD
            |=> cmp_threshold == $past(req.wdata[CODE_W-1:0]))
        else $error("threshold code not taken from write");

    chk_reset_values: assert property (
        $past(!rst_n) |-> !cmp_enable && cmp_threshold == RESET_CODE)
        else $error("control bits not cleared by reset");

    chk_reserved_zero: assert property (
        req.rd && (req.addr == OFS_ENABLE || req.addr == OFS_RESULT)
            |=> rdata[DATA_W-1:1] == 7'h00)
        else $error("reserved bits read as nonzero");

    chk_reserved_code: assert property (
        req.rd && req.addr == OFS_THRESHOLD
            |=> rdata == {3'h0, $past(cmp_threshold)})
        else $error("threshold read returned wrong value");

    // both stages are reset, so for two cycles after release they
    // show the reset value rather than the pin
    chk_sync_delay: assert property (
        $past(rst_n) && $past(rst_n, 2) |-> st.sync_2 == $past(cmp_below, 2))
        else $error("synchroniser depth is not two");

    // control outputs move only on a write to their own register
    chk_enable_hold: assert property (
        !(req.wr && req.addr == OFS_ENABLE) |=> $stable(cmp_enable))
        else $error("comparator enable moved without a write");

    chk_threshold_hold: assert property (
        !(req.wr && req.addr == OFS_THRESHOLD) |=> $stable(cmp_threshold))
        else $error("threshold code moved without a write");

    chk_code_keeps_en: assert property (
        seq_threshold_write |=> $stable(cmp_enable))
        else $error("threshold write touched the comparator enable");

    chk_disable_stops: assert property (
        seq_disable_write |=> !cmp_enable && st.state == ST_IDLE)
        else $error("disable write left detection running");

    // the enable pin comes from detect_enable, a separate copy that must match the state
    chk_enable_mirror: assert property (
        cmp_enable == (st.state == ST_DETECT))
        else $error("comparator enable disagrees with the state");

    chk_flag_live: assert property (
        st.state == ST_DETECT |=> st.undervoltage_flag == $past(st.sync_2))
        else $error("flag did not take the synchronised outcome");

    chk_result_readonly: assert property (
        seq_result_write ##0 !cmp_enable |=> $stable(st.undervoltage_flag))
        else $error("write to the result register changed the flag");

    // read data stand one cycle only, so a missed read cannot alias
    chk_read_idle: assert property (
        !req.rd |=> rdata == RESET_RDATA)
        else $error("read data stood longer than one cycle");

    // holes in the map read as zero and never hang the bus
    chk_unmapped_read: assert property (
        req.rd && (req.addr < OFS_ENABLE || req.addr > OFS_MASK) |=> rdata == RESET_RDATA)
        else $error("unmapped read returned nonzero data");

    // mask has the same layout as status
    chk_mask_write: assert property (
        req.wr && req.addr == OFS_MASK |=> st.mask == $past(req.wdata[EVT_W-1:0]))
        else $error("mask not taken from write");

    chk_status_read: assert property (
        seq_status_read |=> rdata == {6'h00, $past(st.status)})
        else $error("status read returned wrong value");

    // nothing can raise an event while off, so an idle read empties it
    chk_status_clear: assert property (
        seq_status_read ##0 st.state == ST_IDLE |=> st.status == RESET_EVT)
        else $error("status read while idle did not clear it");

    // a stale flag on the first live cycle must not look like an edge
    chk_first_quiet: assert property (
        seq_first_live ##0 !rd_status |=> st.status == $past(st.status))
        else $error("event raised on the first live cycle");

    chk_idle_quiet: assert property (
        st.state == ST_IDLE && !rd_status |=> st.status == $past(st.status))
        else $error("event raised while detection was off");

    // the set must win over a clearing read in the same cycle
    chk_below_sets: assert property (
        st.primed && st.state == ST_DETECT && st.sync_2 && !st.undervoltage_flag
            |=> st.status[EVT_BELOW])
        else $error("fall below the threshold was not recorded");

    chk_recover_sets: assert property (
        st.primed && st.state == ST_DETECT && !st.sync_2 && st.undervoltage_flag
            |=> st.status[EVT_RECOVER])
        else $error("recovery above the threshold was not recorded");

    // irq is registered from the next status, so it tracks with no lag
    chk_irq_level: assert property (
        irq == |(st.status & st.mask))
        else $error("interrupt disagrees with status and mask");

endmodule // supply_monitor_ctrl

// ---- verif/supply_comparator_model.sv ----
// behavioural comparator watching the main supply rail
`timescale 1ns/1ns
module supply_comparator_model
    import supply_monitor_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              cmp_enable,
    input  wire logic [CODE_W-1:0] cmp_threshold,
    input  wire logic [15:0]       supply_mv,
    output logic                   cmp_below
);
    int level_mv;
    assign level_mv = 2000 + (int'(cmp_threshold) - 14) * 100;
    // off or reserved code: no steady answer
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cmp_below <= 1'b0;
        end else if (cmp_enable && cmp_threshold >= 5'h0e && cmp_threshold <= 5'h1a) begin
            cmp_below <= int'(supply_mv) < level_mv;
        end else begin
            cmp_below <= ~cmp_below;
        end
    end
endmodule // supply_comparator_model

// ---- verif/tb_supply_monitor_ctrl.sv ----
// register-level bench for the supply monitor control block
`timescale 1ns/1ns
module tb_supply_monitor_ctrl;
    import supply_monitor_pkg::*;
    localparam int WAIT_CYC = 8;
    logic              clk_sys;
    logic              rst_n;
    reg_req_t          req;
    logic [DATA_W-1:0] rdata;
    logic              cmp_below;
    logic              cmp_enable;
    logic [CODE_W-1:0] cmp_threshold;
    logic              irq;
    logic [15:0]       supply_mv;
    int                num_errors;
    int                samples_checked;

    supply_monitor_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
        .cmp_below(cmp_below), .cmp_enable(cmp_enable), .cmp_threshold(cmp_threshold),
        .irq(irq));
    supply_comparator_model i_cmp (.clk_sys(clk_sys), .rst_n(rst_n), .cmp_enable(cmp_enable),
        .cmp_threshold(cmp_threshold), .supply_mv(supply_mv), .cmp_below(cmp_below));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: w, rd: ~w};
        @(posedge clk_sys);
        req <= '0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] want);
        access(a, 8'h00, 1'b0);
        #1 check(rdata, want);
    endtask

    // settle one ns past the edge so flops have landed
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk_sys);
        num_errors++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        req = '0;
        supply_mv = 16'd3000;
        num_errors = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 check(8'(cmp_enable), 8'h00);
        rd(OFS_ENABLE, 8'h00);
        rd(OFS_THRESHOLD, 8'h00);
        for (int c = 14; c <= 26; c++) begin
            access(OFS_THRESHOLD, 8'(c), 1'b1);
            #1 check(8'(cmp_threshold), 8'(c));
            rd(OFS_THRESHOLD, 8'(c));
        end
        access(OFS_THRESHOLD, 8'h18, 1'b1);
        access(OFS_ENABLE, 8'h01, 1'b1);
        #1 check(8'(cmp_enable), 8'h01);
        rd(OFS_ENABLE, 8'h01);
        wait_cyc(WAIT_CYC);
        rd(OFS_RESULT, 8'h00);
        access(OFS_STATUS, 8'h00, 1'b0);
        // 3.10 V level above a 3.00 V rail
        access(OFS_THRESHOLD, 8'h19, 1'b1);
        wait_cyc(WAIT_CYC);
        check(8'(irq), 8'h00);
        rd(OFS_RESULT, 8'h01);
        rd(OFS_STATUS, 8'h01);
        rd(OFS_STATUS, 8'h00);
        access(OFS_MASK, 8'h03, 1'b1);
        access(OFS_THRESHOLD, 8'h18, 1'b1);
        wait_cyc(WAIT_CYC);
        check(8'(irq), 8'h01);
        rd(OFS_RESULT, 8'h00);
        rd(OFS_STATUS, 8'h02);
        check(8'(irq), 8'h00);
        access(OFS_THRESHOLD, 8'h19, 1'b1);
        wait_cyc(WAIT_CYC);
        access(OFS_ENABLE, 8'h00, 1'b1);
        wait_cyc(WAIT_CYC);
        check(8'(cmp_enable), 8'h00);
        rd(OFS_RESULT, 8'h01);
        access(OFS_RESULT, 8'h00, 1'b1);
        rd(OFS_RESULT, 8'h01);
        // idle comparator toggles, yet no event may appear
        rd(OFS_STATUS, 8'h01);
        rd(16'h5105, 8'h00);
        close_out();
    end
endmodule // tb_supply_monitor_ctrl
